// File: verilog/adchc_pkg.sv
// ==========================================================================
// shared constants and carriers
package adchc_pkg;

  // ========================================================================
  // widths
  localparam int DATA_W = 18;
  localparam int CNT_W  = 8;

  // ========================================================================
  // timing: figures in their own unit, counts derived from the clock rate
  localparam int CLK_MHZ      = 25;
  localparam int CONV_TIME_NS = 700;   // internal conversion time
  localparam int CAL_TIME_NS  = 2000;  // calibration phase after reset
  localparam int CONV_CYCLES  = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int CAL_CYCLES   = (CAL_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);
  localparam logic [CNT_W-1:0] CAL_LAST  = CNT_W'(CAL_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO  = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE   = 8'h01;

  // ========================================================================
  // reference figure driven on the reference pin when internal
  localparam int REF_INTERNAL_MV = 2048;

  // ========================================================================
  // reset values
  localparam logic [DATA_W-1:0] DATA_RST = 18'h0_0000;
  localparam int                MSB     = DATA_W - 1;

  // ========================================================================
  // control state
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RESET,
    ST_CAL,
    ST_CONV,
    ST_SLEEP
  } adchc_state_t;

  // control pins from the host
  typedef struct packed {
    logic reset_in;
    logic power_down_in;
    logic conversion_start_n;
    logic ref_shutdown_in;
    logic ref_buffer_shutdown_in;
  } adchc_ctl_t;

  // read-side pins from the host
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic sclk;
  } adchc_rd_t;

endpackage

// File: verilog/adchc_top.sv
`timescale 1ns/1ns
// Contract
// - The output bus is driven only while device select and read are both low.
// - The host serial clock shifts data only while device select is low.
// - A high reset input holds the device in reset and drops any conversion unfinished.
// - The fall of the reset input starts calibration, with busy high throughout.
// - Power-down lets a running conversion finish, then ignores further starts.
// - A falling conversion start switches track to hold and begins a conversion.
// - Low shutdown inputs enable the internal 2.048 V reference and buffer, high disables them.
// - Busy rises at conversion start and falls once the result is in the shift register.
module adchc_top (
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  // host pins
  input  wire adchc_pkg::adchc_ctl_t      ctl,
  input  wire adchc_pkg::adchc_rd_t       rdp,
  // result word from the analog core
  input  wire logic [adchc_pkg::MSB:0]    sar_result,
  // status and sampling stage
  output logic                            busy,
  output logic                            hold,
  // output bus: enable low while driving
  output logic [adchc_pkg::MSB:0]         data_out,
  output logic                            data_oe_n,
  output logic                            sdout,
  output logic                            sdout_oe_n,
  // reference control
  output logic                            int_ref_en,
  output logic                            ref_buf_en
);

  // ========================================================================
  // state
  adchc_pkg::adchc_state_t         state_reg, state_next;
  logic [adchc_pkg::CNT_W-1:0]     cnt_reg, cnt_next;
  logic                            busy_reg, busy_next;
  logic                            hold_reg, hold_next;
  logic                            start_prev_reg;
  logic                            sclk_prev_reg;
  logic [adchc_pkg::MSB:0]         shift_reg, shift_next;
  logic [adchc_pkg::MSB:0]         word_reg, word_next;
  logic                            oe_n_reg, oe_n_next;
  logic                            ref_en_reg, ref_en_next;
  logic                            buf_en_reg, buf_en_next;
  logic                            start_fall;
  logic                            load_now;
  logic                            sclk_rise;

  // edge detectors on synchronous inputs
  assign start_fall = start_prev_reg & ~ctl.conversion_start_n;
  assign sclk_rise  = ~sclk_prev_reg & rdp.sclk;

  // ========================================================================
  // control sequencer next state
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    busy_next  = busy_reg;
    hold_next  = hold_reg;
    load_now   = 1'b0;
    if (ctl.reset_in) begin
      state_next = adchc_pkg::ST_RESET;
      cnt_next   = adchc_pkg::CNT_ZERO;
      busy_next  = 1'b0;
      hold_next  = 1'b0;
    end else begin
      case (state_reg)
        adchc_pkg::ST_RESET: begin
          state_next = adchc_pkg::ST_CAL;
          cnt_next   = adchc_pkg::CNT_ZERO;
          busy_next  = 1'b1;
        end
        adchc_pkg::ST_CAL: begin
          if (cnt_reg == adchc_pkg::CAL_LAST) begin
            state_next = adchc_pkg::ST_IDLE;
            busy_next  = 1'b0;
          end else begin
            cnt_next = cnt_reg + adchc_pkg::CNT_ONE;
          end
        end
        adchc_pkg::ST_IDLE: begin
          if (ctl.power_down_in) begin
            state_next = adchc_pkg::ST_SLEEP;
          end else if (start_fall) begin
            state_next = adchc_pkg::ST_CONV;
            cnt_next   = adchc_pkg::CNT_ZERO;
            busy_next  = 1'b1;
            hold_next  = 1'b1;
          end
        end
        adchc_pkg::ST_CONV: begin
          // starts during a conversion are not honoured
          if (cnt_reg == adchc_pkg::CONV_LAST) begin
            load_now   = 1'b1;
            busy_next  = 1'b0;
            hold_next  = 1'b0;
            state_next = ctl.power_down_in ? adchc_pkg::ST_SLEEP
                                           : adchc_pkg::ST_IDLE;
          end else begin
            cnt_next = cnt_reg + adchc_pkg::CNT_ONE;
          end
        end
        adchc_pkg::ST_SLEEP: begin
          if (!ctl.power_down_in) begin
            state_next = adchc_pkg::ST_IDLE;
          end
        end
        default: begin
          state_next = adchc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // control sequencer registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg      <= adchc_pkg::ST_IDLE;
      cnt_reg        <= adchc_pkg::CNT_ZERO;
      busy_reg       <= 1'b0;
      hold_reg       <= 1'b0;
      start_prev_reg <= 1'b1;
    end else begin
      state_reg      <= state_next;
      cnt_reg        <= cnt_next;
      busy_reg       <= busy_next;
      hold_reg       <= hold_next;
      start_prev_reg <= ctl.conversion_start_n;
    end
  end

  // ========================================================================
  // output data path next values
  always_comb begin
    word_next  = word_reg;
    shift_next = shift_reg;
    if (load_now) begin
      word_next  = sar_result;
      shift_next = sar_result;
    end else if (sclk_rise && !rdp.cs_n) begin
      shift_next = {shift_reg[adchc_pkg::MSB-1:0], 1'b0};
    end
    oe_n_next   = rdp.cs_n | rdp.rd_n;
    ref_en_next = ~ctl.ref_shutdown_in;
    buf_en_next = ~ctl.ref_buffer_shutdown_in;
  end

  // output data path registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      word_reg      <= adchc_pkg::DATA_RST;
      shift_reg     <= adchc_pkg::DATA_RST;
      oe_n_reg      <= 1'b1;
      ref_en_reg    <= 1'b0;
      buf_en_reg    <= 1'b0;
      sclk_prev_reg <= 1'b0;
    end else begin
      word_reg      <= word_next;
      shift_reg     <= shift_next;
      oe_n_reg      <= oe_n_next;
      ref_en_reg    <= ref_en_next;
      buf_en_reg    <= buf_en_next;
      sclk_prev_reg <= rdp.sclk;
    end
  end

  // outputs straight from flops
  assign busy       = busy_reg;
  assign hold       = hold_reg;
  assign data_out   = word_reg;
  assign data_oe_n  = oe_n_reg;
  assign sdout      = shift_reg[adchc_pkg::MSB];
  assign sdout_oe_n = oe_n_reg;
  assign int_ref_en = ref_en_reg;
  assign ref_buf_en = buf_en_reg;

  // ========================================================================
  // checks
  localparam int CONV_CYC = adchc_pkg::CONV_CYCLES;

  // bus drives only under select and read
  a_bus_enable_gate: assert property (@(posedge sys_clk) disable iff (rst)
    !rst |=> (data_oe_n == ($past(rdp.cs_n) | $past(rdp.rd_n))))
    else $error("bus enable does not follow select and read");

  // deselected serial clock leaves the shifter alone
  a_sclk_cs_gate: assert property (@(posedge sys_clk) disable iff (rst)
    (rdp.cs_n && sclk_rise && !load_now) |=> $stable(shift_reg))
    else $error("serial clock shifted while deselected");

  // reset input aborts and holds
  a_reset_abort: assert property (@(posedge sys_clk) disable iff (rst)
    ctl.reset_in |=> (!busy && !hold && state_reg == adchc_pkg::ST_RESET))
    else $error("reset input did not abort");

  // calibration shows busy after reset release
  a_cal_busy_high: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == adchc_pkg::ST_RESET && !ctl.reset_in) ##1 !ctl.reset_in[*8]
      |-> busy[*8])
    else $error("busy not high during calibration");

  // starts ignored while powered down
  a_sleep_ignore: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == adchc_pkg::ST_SLEEP && !ctl.reset_in && start_fall) |=> !busy)
    else $error("conversion started while powered down");

  // start edge holds and raises busy
  a_start_hold: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == adchc_pkg::ST_IDLE && !ctl.reset_in && !ctl.power_down_in
     && start_fall) |=> (hold && busy))
    else $error("start edge did not begin a conversion");

  // reference enables follow the shutdown inputs
  a_ref_follow: assert property (@(posedge sys_clk) disable iff (rst)
    !rst |=> (int_ref_en == !$past(ctl.ref_shutdown_in)
              && ref_buf_en == !$past(ctl.ref_buffer_shutdown_in)))
    else $error("reference enable wrong");

  // busy falls with the result loaded
  a_busy_result: assert property (@(posedge sys_clk) disable iff (rst)
    (load_now && !ctl.reset_in) |=> (!busy && word_reg == $past(sar_result)))
    else $error("result not latched when busy fell");

  // conversion ends in bounded time
  a_conv_bound: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(busy) && state_reg == adchc_pkg::ST_CONV |-> ##[1:CONV_CYC] !busy)
    else $error("conversion did not finish");

endmodule

// File: verification/adchc_host_model.sv
`timescale 1ns/1ns
// ==========================================================================
// host model: drives control and read pins of the converter
module adchc_host_model (
  // clock and status from the device
  input  wire logic             sys_clk,
  input  wire logic             busy,
  // host pins
  output adchc_pkg::adchc_ctl_t ctl,
  output adchc_pkg::adchc_rd_t  rdp
);
  // idle pins: start high, select and read released
  initial begin
    ctl = 5'h04;
    rdp = 3'h6;
  end

  // reference shutdowns, power-down and device reset
  task automatic set_ctl(input logic rs, input logic rb, input logic pd, input logic ri);
    @(posedge sys_clk);
    ctl.ref_shutdown_in        <= rs;
    ctl.ref_buffer_shutdown_in <= rb;
    ctl.power_down_in          <= pd;
    ctl.reset_in               <= ri;
  endtask

  // select, read and serial clock; the clock only counts while selected
  task automatic set_rd(input logic cs, input logic rd, input logic sck);
    @(posedge sys_clk);
    rdp <= {cs, rd, sck};
  endtask

  // falling start edge, issued once busy is low or after 100 cycles of waiting
  task automatic start();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    ctl.conversion_start_n <= 1'b0;
    @(posedge sys_clk);
    ctl.conversion_start_n <= 1'b1;
  endtask
endmodule

// File: verification/testbench.sv
`timescale 1ns/1ns
// ==========================================================================
// self-checking bench for the converter control
module testbench;
  // row: shutdowns, select, read, then expected enables and output enable
  typedef struct packed {
    logic rs, rb, cs, rd, ref_en, buf_en, oe_n;
  } adchc_row_t;

  logic                    sys_clk = 1'b0;
  logic                    rst     = 1'b1;
  logic [adchc_pkg::MSB:0] sar_result = 18'h0_0000;
  adchc_pkg::adchc_ctl_t   ctl;
  adchc_pkg::adchc_rd_t    rdp;
  logic                    busy, hold, data_oe_n, sdout, sdout_oe_n, int_ref_en, ref_buf_en;
  logic [adchc_pkg::MSB:0] data_out;
  int                      err_count = 0;
  int                      comparisons = 0;
  int                      len;
  adchc_row_t              rows [4] = '{7'h06, 7'h2d, 7'h53, 7'h79};

  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;

  adchc_top u_adchc_top (.sys_clk(sys_clk), .rst(rst), .ctl(ctl), .rdp(rdp),
    .sar_result(sar_result), .busy(busy), .hold(hold), .data_out(data_out),
    .data_oe_n(data_oe_n), .sdout(sdout), .sdout_oe_n(sdout_oe_n),
    .int_ref_en(int_ref_en), .ref_buf_en(ref_buf_en));

  adchc_host_model u_adchc_host_model (.sys_clk(sys_clk), .busy(busy), .ctl(ctl), .rdp(rdp));

  // ========================================================================
  // helpers
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // counts settled cycles with busy high, starting just after the current edge
  task automatic busy_len(output int n);
    n = 0;
    #1;
    while (busy === 1'b1 && n < 200) begin
      n++;
      @(posedge sys_clk);
      #1;
    end
  endtask

  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ========================================================================
  // watchdog: the sequence needs well under 2000 cycles
  initial begin
    #400_000;
    err_count++;
    results();
  end

  // ========================================================================
  // main sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    // table of reference and output enable cases
    foreach (rows[i]) begin
      u_adchc_host_model.set_ctl(rows[i].rs, rows[i].rb, 1'b0, 1'b0);
      u_adchc_host_model.set_rd(rows[i].cs, rows[i].rd, 1'b0);
      repeat (2) @(posedge sys_clk);
      #1;
      chk(int_ref_en, rows[i].ref_en);
      chk(ref_buf_en, rows[i].buf_en);
      chk(data_oe_n, rows[i].oe_n);
      chk(sdout_oe_n, rows[i].oe_n);
    end
    u_adchc_host_model.set_rd(1'b1, 1'b1, 1'b0);
    // plain conversion: busy length, hold high at start and low at end, result loaded at the end
    sar_result <= 18'h2_5a3c;
    u_adchc_host_model.start();
    #1;
    chk(hold, 1'b1);
    busy_len(len);
    chk(len, adchc_pkg::CONV_CYCLES);
    chk(hold, 1'b0);
    chk(data_out, 18'h2_5a3c);
    // read: bus enabled, serial msb first; clock ignored while deselected
    u_adchc_host_model.set_rd(1'b0, 1'b0, 1'b0);
    repeat (2) @(posedge sys_clk);
    #1;
    chk(data_oe_n, 1'b0);
    chk(sdout, 1'b1);
    u_adchc_host_model.set_rd(1'b1, 1'b0, 1'b1);
    u_adchc_host_model.set_rd(1'b1, 1'b0, 1'b0);
    repeat (2) @(posedge sys_clk);
    #1;
    chk(sdout, 1'b1);
    u_adchc_host_model.set_rd(1'b0, 1'b0, 1'b1);
    u_adchc_host_model.set_rd(1'b0, 1'b0, 1'b0);
    repeat (2) @(posedge sys_clk);
    #1;
    chk(sdout, 1'b0);
    u_adchc_host_model.set_rd(1'b1, 1'b1, 1'b0);
    // device reset in mid-conversion: abandoned, then calibration
    sar_result <= 18'h1_1111;
    u_adchc_host_model.start();
    repeat (4) @(posedge sys_clk);
    u_adchc_host_model.set_ctl(1'b0, 1'b0, 1'b0, 1'b1);
    repeat (2) @(posedge sys_clk);
    #1;
    chk(busy, 1'b0);
    chk(hold, 1'b0);
    chk(data_out, 18'h2_5a3c);
    u_adchc_host_model.set_ctl(1'b0, 1'b0, 1'b0, 1'b0);
    @(posedge sys_clk);
    busy_len(len);
    chk(len, adchc_pkg::CAL_CYCLES);
    // power-down during conversion: finishes, then starts are ignored
    sar_result <= 18'h3_c0f0;
    u_adchc_host_model.start();
    u_adchc_host_model.set_ctl(1'b0, 1'b0, 1'b1, 1'b0);
    busy_len(len);
    chk(data_out, 18'h3_c0f0);
    u_adchc_host_model.start();
    busy_len(len);
    chk(len, 0);
    u_adchc_host_model.set_ctl(1'b0, 1'b0, 1'b0, 1'b0);
    repeat (2) @(posedge sys_clk);
    u_adchc_host_model.start();
    busy_len(len);
    chk(len, adchc_pkg::CONV_CYCLES);
    // mid-run reset: outputs back to reset values, then follow inputs again
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk(data_out, adchc_pkg::DATA_RST);
    chk(sdout, 1'b0);
    chk(data_oe_n, 1'b1);
    @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(int_ref_en, 1'b1);
    chk(busy, 1'b0);
    results();
  end
endmodule
